// *** pkg/rbx_consts.svh ***
`ifndef RBX_CONSTS_SVH
`define RBX_CONSTS_SVH

// Port widths, half count and FIFO depth
`define RBX_NARROW_W 12
`define RBX_HALVES 2
`define RBX_FIFO_DEPTH 8
`define RBX_AXI_ADDR_W 8
`define RBX_AXI_DATA_W 32
`define RBX_AXI_STRB_W 4

// Register byte offsets
`define RBX_OFS_CTRL 8'h00
`define RBX_OFS_STATUS 8'h04
`define RBX_OFS_TXDATA 8'h08
`define RBX_OFS_WIDE 8'h0C
`define RBX_OFS_NARROW 8'h10

// Control register fields
`define RBX_CTRL_SRC_BIT 0
`define RBX_CTRL_RESET 1'h0

// Status register fields
`define RBX_STAT_EMPTY_BIT 0
`define RBX_STAT_FULL_BIT 1
`define RBX_STAT_UNDERRUN_BIT 2
`define RBX_STAT_SRC_BIT 3
`define RBX_STAT_COUNT_LSB 8

// Response codes
`define RBX_RESP_OKAY 2'h0
`define RBX_RESP_SLVERR 2'h2

// Reset values of the pin-facing registers
`define RBX_OE_N_RESET 1'h1
`define RBX_DATA_RESET 12'h000

`endif

// *** pkg/rbx_pkg.sv ***
`default_nettype none

`include "rbx_consts.svh"

package rbx_pkg;

  typedef logic [`RBX_AXI_ADDR_W-1:0] rbx_axi_addr_t;
  typedef logic [`RBX_AXI_DATA_W-1:0] rbx_axi_data_t;
  typedef logic [`RBX_AXI_STRB_W-1:0] rbx_axi_strb_t;
  typedef logic [1:0] rbx_resp_t;

  typedef enum logic [1:0] {
    RBX_WR_COLLECT = 2'b00,
    RBX_WR_PUSH = 2'b01,
    RBX_WR_RESP = 2'b10
  } rbx_wr_state_e;

endpackage : rbx_pkg

`default_nettype wire

// *** rtl/rbx_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

module rbx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr + 1'b1);
      end
      if (push && !pop)
      begin
        count <= CW'(count + 1'b1);
      end
      else if (pop && !push)
      begin
        count <= CW'(count - 1'b1);
      end
    end
  end

endmodule : rbx_fifo

`default_nettype wire

// *** rtl/rbx_exchanger.sv ***
// Summary of operation
// - Wide half register loads narrow data only at rising edge with its enable low.
// - One enable low loads only that half; the other half holds.
// - Both enables low load both halves alike; both high hold both.
// - Wide-to-narrow direction uses one single storage register.
// - Narrow register loads first half when select high, second when low.
// - Half select routes the chosen wide half to the narrow outputs.
// - Narrow outputs come from a register, never combinationally from wide inputs.
// - All control inputs are sampled by registers at the rising edge.
// - Each port drives only while its registered active-low enable is low.
// - Output drive state is updated at every rising clock edge from the enable pins.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

`include "rbx_consts.svh"

module rbx_exchanger #(
  parameter int NARROW_W = `RBX_NARROW_W,
  parameter int FIFO_DEPTH = `RBX_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire rbx_pkg::rbx_axi_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire rbx_pkg::rbx_axi_data_t s_axi_wdata,
  input wire rbx_pkg::rbx_axi_strb_t s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output rbx_pkg::rbx_resp_t s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire rbx_pkg::rbx_axi_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rbx_pkg::rbx_axi_data_t s_axi_rdata,
  output rbx_pkg::rbx_resp_t s_axi_rresp,
  // Control pins
  input wire logic first_half_load_enable_n,
  input wire logic second_half_load_enable_n,
  input wire logic half_select,
  input wire logic narrow_port_output_enable_n,
  input wire logic first_half_output_enable_n,
  input wire logic second_half_output_enable_n,
  // Narrow port
  input wire logic [NARROW_W-1:0] narrow_port_in,
  output logic [NARROW_W-1:0] narrow_port_out,
  output logic narrow_port_oe_n,
  // Wide port, first half
  input wire logic [NARROW_W-1:0] wide_first_half_port_in,
  output logic [NARROW_W-1:0] wide_first_half_port_out,
  output logic wide_first_half_port_oe_n,
  // Wide port, second half
  input wire logic [NARROW_W-1:0] wide_second_half_port_in,
  output logic [NARROW_W-1:0] wide_second_half_port_out,
  output logic wide_second_half_port_oe_n
);

  import rbx_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH+1);

  // Per-half views of the pins
  logic [`RBX_HALVES-1:0] load_en_n;
  logic [`RBX_HALVES-1:0] half_oe_n_in;
  logic [NARROW_W-1:0] half_q [`RBX_HALVES];
  logic [`RBX_HALVES-1:0] half_oe_n_q;

  // Narrow-side storage
  logic [NARROW_W-1:0] narrow_q;
  logic narrow_oe_n_q;

  // Software state
  logic src_sw;
  logic underrun;

  // FIFO wiring
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [NARROW_W-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;

  // Load path
  logic [NARROW_W-1:0] load_data;
  logic any_load;
  logic load_ok;

  // Write channel
  rbx_wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  rbx_axi_addr_t aw_addr_q;
  rbx_axi_data_t w_data_q;
  rbx_axi_strb_t w_strb_q;
  logic wr_commit;
  logic wr_mapped;

  // Read channel
  rbx_axi_data_t next_rdata;
  rbx_resp_t next_rresp;

  assign load_en_n = {second_half_load_enable_n, first_half_load_enable_n};
  assign half_oe_n_in = {second_half_output_enable_n, first_half_output_enable_n};

  // Narrow word source: pins, or FIFO head in software mode
  assign load_data = src_sw ? fifo_out_data : narrow_port_in;
  assign any_load = (load_en_n != '1);
  assign load_ok = !src_sw || fifo_out_valid;
  assign fifo_out_ready = src_sw && any_load;

  // Wide halves, each with its own enable and output enable
  genvar gi;
  generate
    for (gi = 0; gi < `RBX_HALVES; gi++)
    begin : g_half
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          half_q[gi] <= `RBX_DATA_RESET;
        end
        else if (!load_en_n[gi] && load_ok)
        begin
          half_q[gi] <= load_data;
        end
      end

      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          half_oe_n_q[gi] <= `RBX_OE_N_RESET;
        end
        else
        begin
          half_oe_n_q[gi] <= half_oe_n_in[gi];
        end
      end
    end
  endgenerate

  assign wide_first_half_port_out = half_q[0];
  assign wide_second_half_port_out = half_q[1];
  assign wide_first_half_port_oe_n = half_oe_n_q[0];
  assign wide_second_half_port_oe_n = half_oe_n_q[1];

  // Single register toward the narrow port
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      narrow_q <= `RBX_DATA_RESET;
    end
    else
    begin
      narrow_q <= half_select ? wide_first_half_port_in : wide_second_half_port_in;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      narrow_oe_n_q <= `RBX_OE_N_RESET;
    end
    else
    begin
      narrow_oe_n_q <= narrow_port_output_enable_n;
    end
  end

  assign narrow_port_out = narrow_q;
  assign narrow_port_oe_n = narrow_oe_n_q;

  // Software-fed narrow words
  rbx_fifo #(
    .WIDTH(NARROW_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(w_data_q[NARROW_W-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  assign fifo_in_valid = (wr_state == RBX_WR_PUSH);

  // Address decode of the held write
  assign wr_mapped = (aw_addr_q == `RBX_OFS_CTRL) || (aw_addr_q == `RBX_OFS_STATUS) ||
                     (aw_addr_q == `RBX_OFS_TXDATA) || (aw_addr_q == `RBX_OFS_WIDE) ||
                     (aw_addr_q == `RBX_OFS_NARROW);
  assign wr_commit = (wr_state == RBX_WR_COLLECT) && aw_held && w_held;

  // Write channel: address and data in either order, response after both
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_state <= RBX_WR_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RBX_RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        RBX_WR_COLLECT:
        begin
          if (s_axi_awvalid && s_axi_awready)
          begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready)
          begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (wr_commit)
          begin
            if (aw_addr_q == `RBX_OFS_TXDATA)
            begin
              wr_state <= RBX_WR_PUSH;
            end
            else
            begin
              wr_state <= RBX_WR_RESP;
              s_axi_bvalid <= 1'b1;
              s_axi_bresp <= wr_mapped ? `RBX_RESP_OKAY : `RBX_RESP_SLVERR;
            end
          end
        end
        RBX_WR_PUSH:
        begin
          // Stalls here while the FIFO is full
          if (fifo_in_ready)
          begin
            wr_state <= RBX_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RBX_RESP_OKAY;
          end
        end
        RBX_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state <= RBX_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
          end
        end
        default:
        begin
          wr_state <= RBX_WR_COLLECT;
        end
      endcase
    end
  end

  // Control register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      src_sw <= `RBX_CTRL_RESET;
    end
    else if (wr_commit && aw_addr_q == `RBX_OFS_CTRL && w_strb_q[0])
    begin
      src_sw <= w_data_q[`RBX_CTRL_SRC_BIT];
    end
  end

  // Underrun: load asked in software mode with FIFO empty; set wins over clear
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      underrun <= 1'b0;
    end
    else if (src_sw && any_load && !fifo_out_valid)
    begin
      underrun <= 1'b1;
    end
    else if (wr_commit && aw_addr_q == `RBX_OFS_STATUS && w_strb_q[0] &&
             w_data_q[`RBX_STAT_UNDERRUN_BIT])
    begin
      underrun <= 1'b0;
    end
  end

  // Read data mux
  always_comb
  begin
    next_rdata = '0;
    next_rresp = `RBX_RESP_OKAY;
    case (s_axi_araddr)
      `RBX_OFS_CTRL:
      begin
        next_rdata[`RBX_CTRL_SRC_BIT] = src_sw;
      end
      `RBX_OFS_STATUS:
      begin
        next_rdata[`RBX_STAT_EMPTY_BIT] = !fifo_out_valid;
        next_rdata[`RBX_STAT_FULL_BIT] = !fifo_in_ready;
        next_rdata[`RBX_STAT_UNDERRUN_BIT] = underrun;
        next_rdata[`RBX_STAT_SRC_BIT] = src_sw;
        next_rdata[`RBX_STAT_COUNT_LSB +: CW] = fifo_count;
      end
      `RBX_OFS_TXDATA:
      begin
        next_rdata = '0;
      end
      `RBX_OFS_WIDE:
      begin
        next_rdata[2*NARROW_W-1:0] = {half_q[1], half_q[0]};
      end
      `RBX_OFS_NARROW:
      begin
        next_rdata[NARROW_W-1:0] = narrow_q;
      end
      default:
      begin
        next_rresp = `RBX_RESP_SLVERR;
      end
    endcase
  end

  // Read channel
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RBX_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : rbx_exchanger

`default_nettype wire

// *** tb/rbx_sdram_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rbx_sdram_model (
  input wire logic [11:0] first_val,
  input wire logic [11:0] second_val,
  input wire logic first_oe_n,
  input wire logic second_oe_n,
  input wire logic [11:0] first_dut,
  input wire logic [11:0] second_dut,
  output logic [11:0] first_wire,
  output logic [11:0] second_wire
);
  // Memory lets go of a half while the exchanger drives it
  assign first_wire = first_oe_n ? first_val : first_dut;
  assign second_wire = second_oe_n ? second_val : second_dut;
endmodule : rbx_sdram_model
`default_nettype wire

// *** tb/rbx_exchanger_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module rbx_exchanger_assertions #(
  parameter int NARROW_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic first_half_load_enable_n,
  input wire logic second_half_load_enable_n,
  input wire logic half_select,
  input wire logic narrow_port_output_enable_n,
  input wire logic first_half_output_enable_n,
  input wire logic second_half_output_enable_n,
  input wire logic [NARROW_W-1:0] wide_first_half_port_in,
  input wire logic [NARROW_W-1:0] wide_second_half_port_in,
  input wire logic [NARROW_W-1:0] narrow_port_out,
  input wire logic [NARROW_W-1:0] wide_first_half_port_out,
  input wire logic [NARROW_W-1:0] wide_second_half_port_out,
  input wire logic narrow_port_oe_n,
  input wire logic wide_first_half_port_oe_n,
  input wire logic wide_second_half_port_oe_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_first_hold: assert property (first_half_load_enable_n |=> $stable(wide_first_half_port_out))
    else $error("first half changed while disabled");
  a_second_hold: assert property (second_half_load_enable_n |=> $stable(wide_second_half_port_out))
    else $error("second half changed while disabled");
  a_both_same: assert property (!first_half_load_enable_n && !second_half_load_enable_n
    |=> wide_first_half_port_out == wide_second_half_port_out)
    else $error("halves differ after joint load");
  a_sel_first: assert property (half_select |=> narrow_port_out == $past(wide_first_half_port_in))
    else $error("narrow register missed first half");
  a_sel_second: assert property (!half_select |=> narrow_port_out == $past(wide_second_half_port_in))
    else $error("narrow register missed second half");
  a_narrow_oe: assert property (##1 narrow_port_oe_n == $past(narrow_port_output_enable_n))
    else $error("narrow enable not registered");
  a_first_oe: assert property (##1 wide_first_half_port_oe_n == $past(first_half_output_enable_n))
    else $error("first half enable not registered");
  a_second_oe: assert property (##1 wide_second_half_port_oe_n == $past(second_half_output_enable_n))
    else $error("second half enable not registered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : rbx_exchanger_assertions
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rbx_pkg::*;
  logic clk_sys, reset;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  rbx_axi_addr_t s_axi_awaddr, s_axi_araddr;
  rbx_axi_data_t s_axi_wdata, s_axi_rdata;
  rbx_resp_t s_axi_bresp, s_axi_rresp;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  rbx_axi_strb_t s_axi_wstrb;
  logic first_half_load_enable_n, second_half_load_enable_n, half_select;
  logic narrow_port_output_enable_n, first_half_output_enable_n, second_half_output_enable_n;
  logic [11:0] nin, fv, sv, narrow_port_out, wide_first_half_port_out, wide_second_half_port_out;
  wire logic [11:0] narrow_port_in, wide_first_half_port_in, wide_second_half_port_in;
  logic narrow_port_oe_n, wide_first_half_port_oe_n, wide_second_half_port_oe_n;
  int errors = 0;
  int tests_run = 0;
  rbx_exchanger dut_u (
    .clk_sys(clk_sys), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .first_half_load_enable_n(first_half_load_enable_n),
    .second_half_load_enable_n(second_half_load_enable_n),
    .half_select(half_select),
    .narrow_port_output_enable_n(narrow_port_output_enable_n),
    .first_half_output_enable_n(first_half_output_enable_n),
    .second_half_output_enable_n(second_half_output_enable_n),
    .narrow_port_in(narrow_port_in), .narrow_port_out(narrow_port_out), .narrow_port_oe_n(narrow_port_oe_n),
    .wide_first_half_port_in(wide_first_half_port_in),
    .wide_first_half_port_out(wide_first_half_port_out),
    .wide_first_half_port_oe_n(wide_first_half_port_oe_n),
    .wide_second_half_port_in(wide_second_half_port_in),
    .wide_second_half_port_out(wide_second_half_port_out),
    .wide_second_half_port_oe_n(wide_second_half_port_oe_n)
  );
  rbx_sdram_model mem_u (.first_val(fv), .second_val(sv), .first_oe_n(wide_first_half_port_oe_n),
    .second_oe_n(wide_second_half_port_oe_n), .first_dut(wide_first_half_port_out),
    .second_dut(wide_second_half_port_out), .first_wire(wide_first_half_port_in),
    .second_wire(wide_second_half_port_in));
  assign narrow_port_in = narrow_port_oe_n ? nin : narrow_port_out;
  task summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task go;
    @(posedge clk_sys);
    #1;
  endtask : go
  task wr(input rbx_axi_addr_t a, input rbx_axi_data_t d, input rbx_resp_t er);
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask : wr
  task rchk(input rbx_axi_addr_t a, input rbx_axi_data_t ed, input rbx_resp_t er);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rchk
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #250000;
    errors++;
    summarize;
  end
  initial
  begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    {first_half_load_enable_n, second_half_load_enable_n, half_select} = 3'h6;
    {narrow_port_output_enable_n, first_half_output_enable_n, second_half_output_enable_n} = 3'h7;
    {nin, fv, sv} = 36'h0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk({narrow_port_oe_n, wide_first_half_port_oe_n, wide_second_half_port_oe_n}, 32'h7);
    chk(wide_first_half_port_out, 32'h0);
    rchk(8'h00, 32'h0, 2'h0);
    @(posedge clk_sys);
    first_half_load_enable_n <= 1'b0;
    nin <= 12'h3C1;
    @(posedge clk_sys);
    first_half_load_enable_n <= 1'b1;
    second_half_load_enable_n <= 1'b0;
    nin <= 12'hC3E;
    #1;
    chk({wide_second_half_port_out, wide_first_half_port_out}, 32'h3C1);
    @(posedge clk_sys);
    second_half_load_enable_n <= 1'b1;
    #1;
    chk(wide_first_half_port_out, 32'h3C1);
    rchk(8'h0C, 32'hC3E3C1, 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
    rchk(8'h0C, 32'hC3E3C1, 2'h0);
    @(posedge clk_sys);
    {first_half_load_enable_n, second_half_load_enable_n} <= 2'h0;
    nin <= 12'h5A5;
    @(posedge clk_sys);
    {first_half_load_enable_n, second_half_load_enable_n} <= 2'h3;
    nin <= 12'hFFF;
    go;
    chk({wide_second_half_port_out, wide_first_half_port_out}, 32'h5A55A5);
    @(posedge clk_sys);
    fv <= 12'h1E7;
    sv <= 12'hE18;
    half_select <= 1'b1;
    @(posedge clk_sys);
    half_select <= 1'b0;
    #1;
    chk(narrow_port_out, 32'h1E7);
    go;
    chk(narrow_port_out, 32'hE18);
    rchk(8'h10, 32'hE18, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      {narrow_port_output_enable_n, first_half_output_enable_n, second_half_output_enable_n} <= 3'(i);
      go;
      chk({narrow_port_oe_n, wide_first_half_port_oe_n, wide_second_half_port_oe_n}, i);
    end
    rchk(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    wr(8'h00, 32'h1, 2'h0);
    for (int i = 0; i < 8; i++)
      wr(8'h08, 32'h0A0 + i, 2'h0);
    rchk(8'h04, 32'h80A, 2'h0);
    @(posedge clk_sys);
    first_half_load_enable_n <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      go;
      chk(wide_first_half_port_out, 32'h0A0 + i);
    end
    @(posedge clk_sys);
    first_half_load_enable_n <= 1'b1;
    rchk(8'h04, 32'h00D, 2'h0);
    wr(8'h04, 32'h4, 2'h0);
    rchk(8'h04, 32'h009, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    summarize;
  end
endmodule : testbench
bind rbx_exchanger rbx_exchanger_assertions #(.NARROW_W(NARROW_W)) chk_u (
  .clk_sys(clk_sys), .reset(reset),
  .first_half_load_enable_n(first_half_load_enable_n),
  .second_half_load_enable_n(second_half_load_enable_n),
  .half_select(half_select),
  .narrow_port_output_enable_n(narrow_port_output_enable_n),
  .first_half_output_enable_n(first_half_output_enable_n),
  .second_half_output_enable_n(second_half_output_enable_n),
  .wide_first_half_port_in(wide_first_half_port_in),
  .wide_second_half_port_in(wide_second_half_port_in),
  .narrow_port_out(narrow_port_out),
  .wide_first_half_port_out(wide_first_half_port_out),
  .wide_second_half_port_out(wide_second_half_port_out),
  .narrow_port_oe_n(narrow_port_oe_n),
  .wide_first_half_port_oe_n(wide_first_half_port_oe_n),
  .wide_second_half_port_oe_n(wide_second_half_port_oe_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire
